//--- design/mfs_status.sv
// Sticky read-clearing fault status registers of the monitor
`timescale 1ns/1ps

// How it works
// - Out-of-window readings set flags automatically, together
// - Flags hold until read, then clear if gone
// - Writes to both status registers are ignored
// - Bits 0-3 flag four supplies, low inclusive
// - Bit 4 flags zone one diode temperature
// - Bit 5 flags zone two die temperature
// - Bit 6 flags zone three diode temperature
// - Bit 7 summarises any secondary flag set
// - Twelve volt flag bit 0, bit 1 zero
// - Bits 2-5 flag stalled fans over minimum
// - Diode faults set secondary and zone flags
// - Temperature comparisons use signed eight bit values
module mfs_status
  import mfs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] fault_status_primary,
  output logic [7:0] fault_status_secondary,
  input wire logic [7:0] supply_two_half,
  input wire logic [7:0] supply_two_half_low,
  input wire logic [7:0] supply_two_half_high,
  input wire logic [7:0] core_supply,
  input wire logic [7:0] core_supply_low,
  input wire logic [7:0] core_supply_high,
  input wire logic [7:0] supply_three_three,
  input wire logic [7:0] supply_three_three_low,
  input wire logic [7:0] supply_three_three_high,
  input wire logic [7:0] supply_five,
  input wire logic [7:0] supply_five_low,
  input wire logic [7:0] supply_five_high,
  input wire logic [7:0] supply_twelve,
  input wire logic [7:0] supply_twelve_low,
  input wire logic [7:0] supply_twelve_high,
  input wire logic [7:0] zone_one_temp,
  input wire logic [7:0] zone_one_low,
  input wire logic [7:0] zone_one_high,
  input wire logic [7:0] zone_two_temp,
  input wire logic [7:0] zone_two_low,
  input wire logic [7:0] zone_two_high,
  input wire logic [7:0] zone_three_temp,
  input wire logic [7:0] zone_three_low,
  input wire logic [7:0] zone_three_high,
  input wire logic [63:0] speed_count,
  input wire logic [63:0] speed_minimum,
  input wire logic diode_one_fault,
  input wire logic diode_two_fault
);

  // ----------------------------------------------------------------------
  // Channel gathering
  // ----------------------------------------------------------------------
  logic [7:0] ch_val [MFS_NUM_WIN];
  logic [7:0] ch_low [MFS_NUM_WIN];
  logic [7:0] ch_high [MFS_NUM_WIN];
  logic [MFS_NUM_WIN-1:0] win_fault;
  logic [MFS_NUM_FAN-1:0] stall;
  logic [7:0] cond_primary;
  logic [7:0] cond_secondary;
  logic rd_primary;
  logic rd_secondary;
  mfs_state_t st_q;
  mfs_state_t st_d;

  // Readings and limits by channel number
  assign ch_val[0] = supply_two_half;
  assign ch_low[0] = supply_two_half_low;
  assign ch_high[0] = supply_two_half_high;
  assign ch_val[1] = core_supply;
  assign ch_low[1] = core_supply_low;
  assign ch_high[1] = core_supply_high;
  assign ch_val[2] = supply_three_three;
  assign ch_low[2] = supply_three_three_low;
  assign ch_high[2] = supply_three_three_high;
  assign ch_val[3] = supply_five;
  assign ch_low[3] = supply_five_low;
  assign ch_high[3] = supply_five_high;
  assign ch_val[4] = zone_one_temp;
  assign ch_low[4] = zone_one_low;
  assign ch_high[4] = zone_one_high;
  assign ch_val[5] = zone_two_temp;
  assign ch_low[5] = zone_two_low;
  assign ch_high[5] = zone_two_high;
  assign ch_val[6] = zone_three_temp;
  assign ch_low[6] = zone_three_low;   // Zone three own low limit
  assign ch_high[6] = zone_three_high;
  assign ch_val[7] = supply_twelve;
  assign ch_low[7] = supply_twelve_low;
  assign ch_high[7] = supply_twelve_high;

  // ----------------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------------
  // One window comparator per channel, zones signed
  for (genvar i = 0; i < MFS_NUM_WIN; i++) begin : g_win
    mfs_window #(
      .SIGNED_CMP(MFS_CH_SIGNED[i]),
      .LOW_INCL(MFS_CH_LOW_INCL[i])
    ) u_win (
      .value(ch_val[i]),
      .low_limit(ch_low[i]),
      .high_limit(ch_high[i]),
      .out_of_range(win_fault[i])
    );
  end

  // Stall when the count exceeds its sixteen bit minimum
  for (genvar f = 0; f < MFS_NUM_FAN; f++) begin : g_fan
    assign stall[f] = speed_count[16*f +: 16] >
                      speed_minimum[16*f +: 16];
  end

  // Live fault conditions in register layout
  always_comb begin
    cond_primary = 8'h00;
    cond_primary[MFS_P_TWO_HALF] = win_fault[0];
    cond_primary[MFS_P_CORE] = win_fault[1];
    cond_primary[MFS_P_THREE_THREE] = win_fault[2];
    cond_primary[MFS_P_FIVE] = win_fault[3];
    cond_primary[MFS_P_ZONE_ONE] = win_fault[4] |
                                   diode_one_fault;
    cond_primary[MFS_P_ZONE_TWO] = win_fault[5];
    cond_primary[MFS_P_ZONE_THREE] = win_fault[6] |
                                     diode_two_fault;
    cond_secondary = 8'h00;
    cond_secondary[MFS_S_TWELVE] = win_fault[7];
    cond_secondary[MFS_S_STALL_LO +: MFS_NUM_FAN] = stall;
    cond_secondary[MFS_S_DIODE_ONE] = diode_one_fault;
    cond_secondary[MFS_S_DIODE_TWO] = diode_two_fault;
  end

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  assign rd_primary = reg_rd && (reg_addr == MFS_ADDR_PRIMARY);
  assign rd_secondary = reg_rd && (reg_addr == MFS_ADDR_SECONDARY);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Sticky flags; a read clears only flags whose fault is gone
  always_comb begin
    st_d = st_q;
    st_d.rvalid = reg_rd;
    // Write strobe and data deliberately take no part here
    if (rd_primary) begin
      st_d.rdata = st_q.primary;
      st_d.primary[6:0] = cond_primary[6:0];
    end else begin
      st_d.primary[6:0] = st_q.primary[6:0] |
                          cond_primary[6:0];
    end
    if (rd_secondary) begin
      st_d.rdata = st_q.secondary;
      st_d.secondary = cond_secondary;
    end else begin
      st_d.secondary = st_q.secondary | cond_secondary;
    end
    if (reg_rd && !rd_primary && !rd_secondary) begin
      st_d.rdata = MFS_UNMAPPED_DATA;
    end
    st_d.secondary[MFS_S_RESERVED] = 1'b0;
    st_d.primary[MFS_P_SUMMARY] = |st_d.secondary;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign fault_status_primary = st_q.primary;
  assign fault_status_secondary = st_q.secondary;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Any live fault is visible in the flags one cycle later
  a_fault_sets_flag: assert property (
    1'b1 |=> ((st_q.primary[6:0] & $past(cond_primary[6:0])) ==
              $past(cond_primary[6:0])) &&
             ((st_q.secondary & $past(cond_secondary)) ==
              $past(cond_secondary)))
    else $error("live fault not latched");

  // Without a read of it, no primary flag in bits 6-0 falls
  a_primary_holds: assert property (
    !rd_primary |=> ((st_q.primary[6:0] & $past(st_q.primary[6:0])) ==
                     $past(st_q.primary[6:0])))
    else $error("primary flag dropped without read");

  // A read leaves exactly the still-present faults, event kept
  a_read_clears: assert property (
    rd_primary |=> st_q.primary[6:0] == $past(cond_primary[6:0]))
    else $error("primary read clear wrong");

  a_read_clears2: assert property (
    rd_secondary |=> st_q.secondary == $past(cond_secondary))
    else $error("secondary read clear wrong");

  // Writes leave the flags to hardware alone
  a_write_ignored: assert property (
    (reg_wr && !reg_rd) |=>
      (st_q.secondary == ($past(st_q.secondary) | $past(cond_secondary))) &&
      (st_q.primary[6:0] ==
       ($past(st_q.primary[6:0]) | $past(cond_primary[6:0]))))
    else $error("write disturbed status flags");

  // Summary bit tracks the secondary register
  a_summary_bit: assert property (
    st_q.primary[MFS_P_SUMMARY] == (|st_q.secondary))
    else $error("summary bit mismatch");

  a_reserved_zero: assert property (
    !st_q.secondary[MFS_S_RESERVED])
    else $error("reserved bit set");

  // Read data is the register content before the clear
  a_read_data: assert property (
    rd_primary |=> reg_rvalid && reg_rdata == $past(st_q.primary))
    else $error("primary read data wrong");

  a_supply_low: assert property (
    (supply_two_half <= supply_two_half_low) |=>
      st_q.primary[MFS_P_TWO_HALF])
    else $error("supply low not flagged");

  a_zone_one_hi: assert property (
    ($signed(zone_one_temp) > $signed(zone_one_high)) |=>
      st_q.primary[MFS_P_ZONE_ONE])
    else $error("zone one high not flagged");

  a_zone_two_lo: assert property (
    ($signed(zone_two_temp) <= $signed(zone_two_low)) |=>
      st_q.primary[MFS_P_ZONE_TWO])
    else $error("zone two low not flagged");

  a_zone_three: assert property (
    ($signed(zone_three_temp) > $signed(zone_three_high)) |=>
      st_q.primary[MFS_P_ZONE_THREE])
    else $error("zone three high not flagged");

  // Zone comparators work on signed readings and limits
  a_signed_neg: assert property (
    win_fault[6:4] == {
      ($signed(zone_three_temp) <= $signed(zone_three_low)) ||
        ($signed(zone_three_temp) > $signed(zone_three_high)),
      ($signed(zone_two_temp) <= $signed(zone_two_low)) ||
        ($signed(zone_two_temp) > $signed(zone_two_high)),
      ($signed(zone_one_temp) <= $signed(zone_one_low)) ||
        ($signed(zone_one_temp) > $signed(zone_one_high))})
    else $error("zone window not signed");

  a_fan_stall: assert property (
    (speed_count[15:0] > speed_minimum[15:0]) |=>
      st_q.secondary[MFS_S_STALL_LO])
    else $error("stall not flagged");

  a_diode_fault: assert property (
    diode_two_fault |=> st_q.secondary[MFS_S_DIODE_TWO] &&
                        st_q.primary[MFS_P_ZONE_THREE] &&
                        st_q.primary[MFS_P_SUMMARY])
    else $error("diode fault not flagged twice");

  a_diode_one: assert property (
    diode_one_fault |=> st_q.secondary[MFS_S_DIODE_ONE] &&
                        st_q.primary[MFS_P_ZONE_ONE] &&
                        st_q.primary[MFS_P_SUMMARY])
    else $error("diode one fault not flagged twice");

  // Twelve volt low bound is strict, unlike the others
  a_twelve_strict: assert property (
    win_fault[7] == ((supply_twelve < supply_twelve_low) ||
                     (supply_twelve > supply_twelve_high)))
    else $error("twelve volt window wrong");

  // Read answer is a single cycle pulse after each strobe
  a_rvalid_pulse: assert property (
    1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read answer pulse wrong");

  // Scenario coverage
  c_read_while_fault: cover property (
    rd_primary && (|cond_primary[6:0]));
  c_flag_cleared: cover property (
    st_q.secondary != 8'h00 ##1 rd_secondary ##1 st_q.secondary == 8'h00);
  c_multi_flags: cover property (
    $countones(st_q.primary) > 1);
  c_write_attempt: cover property (
    reg_wr && reg_addr == MFS_ADDR_PRIMARY);
  c_signed_inside: cover property (
    zone_two_temp[7] && !win_fault[5]);

endmodule : mfs_status

//--- design/mfs_pkg.sv
// Constants shared by the fault status flag block
package mfs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] MFS_ADDR_PRIMARY = 8'h41;
  localparam logic [7:0] MFS_ADDR_SECONDARY = 8'h42;
  localparam logic [7:0] MFS_STATUS_RESET = 8'h00;
  localparam logic [7:0] MFS_UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------------
  // Primary register field positions
  // ----------------------------------------------------------------------
  localparam int MFS_P_TWO_HALF = 0;
  localparam int MFS_P_CORE = 1;
  localparam int MFS_P_THREE_THREE = 2;
  localparam int MFS_P_FIVE = 3;
  localparam int MFS_P_ZONE_ONE = 4;
  localparam int MFS_P_ZONE_TWO = 5;
  localparam int MFS_P_ZONE_THREE = 6;
  localparam int MFS_P_SUMMARY = 7;

  // ----------------------------------------------------------------------
  // Secondary register field positions
  // ----------------------------------------------------------------------
  localparam int MFS_S_TWELVE = 0;
  localparam int MFS_S_RESERVED = 1;
  localparam int MFS_S_STALL_LO = 2;
  localparam int MFS_S_DIODE_ONE = 6;
  localparam int MFS_S_DIODE_TWO = 7;

  // ----------------------------------------------------------------------
  // Window channels: 0..3 supplies, 4..6 zones, 7 twelve volt supply
  // ----------------------------------------------------------------------
  localparam int MFS_NUM_WIN = 8;
  localparam int MFS_NUM_FAN = 4;
  localparam logic [7:0] MFS_CH_SIGNED = 8'h70;
  localparam logic [7:0] MFS_CH_LOW_INCL = 8'h7F;

  // State of the block, registered as a whole
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
    logic [7:0] rdata;
    logic rvalid;
  } mfs_state_t;

endpackage : mfs_pkg

//--- design/mfs_window.sv
// Limit window comparator for one measured channel
`timescale 1ns/1ps

module mfs_window #(
  parameter bit SIGNED_CMP = 1'b0,
  parameter bit LOW_INCL = 1'b1
) (
  input wire logic [7:0] value,
  input wire logic [7:0] low_limit,
  input wire logic [7:0] high_limit,
  output logic out_of_range
);

  logic below;
  logic above;

  // Compare as two's complement or unsigned, low bound optionally inclusive
  always_comb begin
    if (SIGNED_CMP) begin
      above = $signed(value) > $signed(high_limit);
      if (LOW_INCL) begin
        below = $signed(value) <= $signed(low_limit);
      end else begin
        below = $signed(value) < $signed(low_limit);
      end
    end else begin
      above = value > high_limit;
      if (LOW_INCL) begin
        below = value <= low_limit;
      end else begin
        below = value < low_limit;
      end
    end
    out_of_range = below | above;
  end

endmodule : mfs_window

//--- verif/mfs_host.sv
// Host model reading and writing the status registers
`timescale 1ns/1ps
module mfs_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // One read strobe, then a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a; // Stale address never looks valid
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask : rd

  // One write strobe; the device gives no answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
endmodule : mfs_host

//--- verif/test_monitor_fault_status_flags.sv
// Self-checking bench of the fault status flag block
`timescale 1ns/1ps
module test_monitor_fault_status_flags;
  import mfs_pkg::*;
  typedef struct packed {
    logic [3:0] ch;
    logic [15:0] v;
    logic [7:0] ep;
    logic [7:0] es;
  } mfs_row_t;
  logic core_clk, rst_n, reg_rd, reg_wr, reg_rvalid, d1, d2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] fault_status_primary, fault_status_secondary;
  logic [7:0] val [8];
  logic [7:0] lo [8];
  logic [7:0] hi [8];
  logic [63:0] speed_count, speed_minimum;
  int errors = 0;
  int check_count = 0;
  // Channel 0-7 windows, 8-11 fans, 12-13 diodes
  mfs_row_t rows [17] = '{
    '{4'h0, 16'h0010, 8'h01, 8'h00},
    '{4'h1, 16'h00F1, 8'h02, 8'h00},
    '{4'h2, 16'h00F0, 8'h00, 8'h00},
    '{4'h3, 16'h000F, 8'h08, 8'h00},
    '{4'h4, 16'h00CE, 8'h10, 8'h00},
    '{4'h5, 16'h0033, 8'h20, 8'h00},
    '{4'h5, 16'h00F0, 8'h00, 8'h00},
    '{4'h6, 16'h00CD, 8'h40, 8'h00},
    '{4'h7, 16'h0010, 8'h00, 8'h00},
    '{4'h7, 16'h000F, 8'h80, 8'h01},
    '{4'h8, 16'h0201, 8'h80, 8'h04},
    '{4'h9, 16'h0200, 8'h00, 8'h00},
    '{4'h9, 16'h0201, 8'h80, 8'h08},
    '{4'hA, 16'h0201, 8'h80, 8'h10},
    '{4'hB, 16'h0201, 8'h80, 8'h20},
    '{4'hC, 16'h0000, 8'h90, 8'h40},
    '{4'hD, 16'h0000, 8'hC0, 8'h80}
  };

  // ------------------------------------------------------------
  // Design, host model and clock
  // ------------------------------------------------------------
  mfs_status uut (
    .core_clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .fault_status_primary,
    .fault_status_secondary,
    .supply_two_half(val[0]), .supply_two_half_low(lo[0]),
    .supply_two_half_high(hi[0]), .core_supply(val[1]),
    .core_supply_low(lo[1]), .core_supply_high(hi[1]),
    .supply_three_three(val[2]), .supply_three_three_low(lo[2]),
    .supply_three_three_high(hi[2]), .supply_five(val[3]),
    .supply_five_low(lo[3]), .supply_five_high(hi[3]),
    .zone_one_temp(val[4]), .zone_one_low(lo[4]), .zone_one_high(hi[4]),
    .zone_two_temp(val[5]), .zone_two_low(lo[5]), .zone_two_high(hi[5]),
    .zone_three_temp(val[6]), .zone_three_low(lo[6]),
    .zone_three_high(hi[6]), .supply_twelve(val[7]),
    .supply_twelve_low(lo[7]), .supply_twelve_high(hi[7]),
    .speed_count, .speed_minimum,
    .diode_one_fault(d1), .diode_two_fault(d2)
  );
  mfs_host host (
    .core_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .reg_rvalid
  );
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Helpers and compare tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // All readings inside their windows
  task automatic set_ok();
    for (int i = 0; i < 8; i++) begin
      val[i] = (i inside {[4:6]}) ? 8'h00 : 8'h80;
      lo[i] = (i inside {[4:6]}) ? 8'hCE : 8'h10;
      hi[i] = (i inside {[4:6]}) ? 8'h32 : 8'hF0;
    end
    speed_count = {4{16'h0100}};
    speed_minimum = {4{16'h0200}};
    d1 = 1'b0;
    d2 = 1'b0;
  endtask : set_ok
  task automatic apply(input mfs_row_t r);
    if (r.ch < 8) val[r.ch[2:0]] = r.v[7:0];
    else if (r.ch < 12) speed_count[r.ch[1:0]*16 +: 16] = r.v;
    else if (r.ch == 12) d1 = 1'b1;
    else d2 = 1'b1;
  endtask : apply
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk_live(input logic [7:0] ep, input logic [7:0] es);
    check_count++;
    if (fault_status_primary !== ep || fault_status_secondary !== es) begin
      errors++;
      $display("CHECK FAILED at %0t: live %h %h want %h %h", $time,
               fault_status_primary, fault_status_secondary, ep, es);
    end
  endtask : chk_live
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    check_count++;
    if (!ok || d !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: read %h gave %h want %h", $time,
               a, d, exp);
      if (!ok) final_report();
    end
  endtask : chk_rd

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    set_ok();
    tick(12);
    rst_n = 1'b1;
    tick(1);
    chk_live(MFS_STATUS_RESET, MFS_STATUS_RESET);
    chk_rd(8'h40, MFS_UNMAPPED_DATA);
    // At most one fault per row, then clear by reading both registers
    foreach (rows[i]) begin
      apply(rows[i]);
      tick(2);
      chk_live(rows[i].ep, rows[i].es);
      set_ok();
      tick(2);
      chk_live(rows[i].ep, rows[i].es);
      chk_rd(MFS_ADDR_PRIMARY, rows[i].ep);
      chk_rd(MFS_ADDR_SECONDARY, rows[i].es);
      chk_live(8'h00, 8'h00);
    end
    // Several faults at once, reported in one read
    val[0] = 8'h10;
    val[3] = 8'h0F;
    val[5] = 8'h81;
    speed_count[15:0] = 16'h0201;
    tick(2);
    chk_live(8'hA9, 8'h04);
    chk_rd(MFS_ADDR_PRIMARY, 8'hA9);
    chk_live(8'hA9, 8'h04);
    set_ok();
    chk_rd(MFS_ADDR_PRIMARY, 8'hA9);
    chk_rd(MFS_ADDR_SECONDARY, 8'h04);
    chk_live(8'h00, 8'h00);
    // Writes leave sticky flags alone; summary follows secondary
    d2 = 1'b1;
    tick(2);
    d2 = 1'b0;
    host.wr(MFS_ADDR_PRIMARY, 8'h00);
    host.wr(MFS_ADDR_SECONDARY, 8'h00);
    chk_live(8'hC0, 8'h80);
    chk_rd(MFS_ADDR_PRIMARY, 8'hC0);
    chk_live(8'h80, 8'h80);
    chk_rd(MFS_ADDR_SECONDARY, 8'h80);
    chk_live(8'h00, 8'h00);
    // Reset in mid-run drops a held flag
    d1 = 1'b1;
    tick(2);
    rst_n = 1'b0;
    d1 = 1'b0;
    tick(1);
    chk_live(MFS_STATUS_RESET, MFS_STATUS_RESET);
    rst_n = 1'b1;
    tick(2);
    chk_live(8'h00, 8'h00);
    final_report();
  end
endmodule : test_monitor_fault_status_flags
